// *** ccrb_defs.svh ***
`ifndef CCRB_DEFS_SVH
`define CCRB_DEFS_SVH
`define CCRB_DEV_ADDR      7'h4B
`define CCRB_OFF_SYS1      8'h00
`define CCRB_OFF_SYS2      8'h01
`define CCRB_OFF_CLK       8'h02
`define CCRB_OFF_CV        8'h03
`define CCRB_OFF_TH        8'h04
`define CCRB_OFF_FLOOR     8'h05
`define CCRB_OFF_CC        8'h06
`define CCRB_OFF_EOC_A     8'h07
`define CCRB_OFF_EOC_B     8'h08
`define CCRB_OFF_TIMING    8'h09
`define CCRB_OFF_HOSTTO    8'h0A
`define CCRB_OFF_HOLE      8'h0B
`define CCRB_OFF_TEMP      8'h0C
`define CCRB_OFF_TLEVEL    8'h0D
`define CCRB_OFF_STATE     8'h20
`define CCRB_OFF_LIVE      8'h30
`define CCRB_OFF_FAULT     8'h31
`define CCRB_OFF_FLAG_A    8'h32
`define CCRB_OFF_FLAG_B    8'h33
`define CCRB_OFF_MSK_STAT  8'h40
`define CCRB_OFF_MSK_FAULT 8'h41
`define CCRB_OFF_MSK_A     8'h42
`define CCRB_OFF_MSK_B     8'h43
`define CCRB_BIT_REG_RESET 7
`define CCRB_BIT_CHARGE_ENABLE_BIT    7
`define CCRB_BIT_REMIND    3
`define CCRB_BIT_FREQ_SEL  7
`define CCRB_BIT_FIX_FREQ  6
`define CCRB_BIT_SPREAD    5
`define CCRB_BIT_FLOOR_EN  0
`define CCRB_BIT_TEMP_H    4
`define CCRB_BIT_TEMP_L    3
`define CCRB_BIT_STAT_CHG  1
`define CCRB_BIT_FAULT_CHG 0
`define CCRB_RST_SYS2      8'h40
`define CCRB_RST_CV        8'h50
`define CCRB_RST_TH        8'hC0
`define CCRB_RST_FLOOR     8'h0B
`define CCRB_RST_CC        8'hA0
`define CCRB_RST_EOC_A     8'h5C
`define CCRB_RST_HOSTTO    8'h50
`define CCRB_RST_TEMP      8'h08
`define CCRB_RST_TLEVEL    8'h30
`define CCRB_RST_MSK_STAT  8'h00
`define CCRB_RST_MSK_FAULT 8'hE0
`define CCRB_RST_MSK_A     8'hFF
`define CCRB_RST_MSK_B     8'hFF
`define CCRB_FLOOR_MAX     7'h5F
`define CCRB_CC_MIN        5'h06
`define CCRB_CC_MAX        5'h1E
`define CCRB_MCLK_HZ       100000000
`define CCRB_REMIND_S      2
`define CCRB_RELEASE_US    1
`define CCRB_RELEASE_CYC   ((`CCRB_RELEASE_US * `CCRB_MCLK_HZ) / 1000000)
`endif

// *** ccrb_pkg.sv ***
package ccrb_pkg;
    typedef enum logic [2:0] {
        ph_idle  = 3'b000,
        ph_addr  = 3'b001,
        ph_ptr   = 3'b010,
        ph_wdata = 3'b011,
        ph_rdata = 3'b100
    } ccrb_phase_t;

    // Readings from the analog side, all asynchronous to mclk.
    typedef struct packed {
        logic [3:0] temp_code;
        logic [1:0] chg_state;
        logic [2:0] live;
        logic [2:0] fault;
        logic [2:0] evt_a;
        logic [3:0] evt_b;
    } ccrb_obs_t;

    typedef struct packed {
        logic       charge_enable_bit;
        logic       switching_frequency_select;
        logic       fixed_frequency_bit;
        logic       spread_spectrum_enable;
        logic [5:0] battery_voltage_field;
        logic [1:0] thermal_threshold_field;
        logic [6:0] input_voltage_floor_field;
        logic       input_floor_loop_enable;
        logic [4:0] charge_current_field;
        logic       temp_enable;
        logic       temp_avg;
    } ccrb_ctl_t;
endpackage : ccrb_pkg

// *** ccrb_top.sv ***
`timescale 1ns/1ps
`include "ccrb_defs.svh"

// Notes on behaviour
// - Sixteen-level temperature code readable, read-only.
// - Code above warning level sets high flag.
// - Code below release level sets low flag.
// - Code steps 4 degrees; warning default 0011, release default 0000.
// - Input floor field saturates above 1011111.
// - Charge current setpoint 0.6A to 3A.
// - Register reset bit restores all, self-clears.
// - Charge enable resets to disabled.
// - Reminder releases, re-asserts interrupt every 2s.
// - Frequency select: 0 fast, 1 slow.
// - Fixed-frequency bit: 0 varying, 1 fixed.
// - Spread spectrum enable, off at reset.
// - Battery voltage field, reset 010100.
// - Thermal threshold field, default 11.
// - Answer only at address 1001011.
// - Floor loop enable, on at reset.
// - Current field clamps low and high.
// - Status or fault change sets flag.
// - Mask bit 1 blocks its event.
module ccrb_top
    import ccrb_pkg::*;
#(
    parameter int unsigned REMIND_CYC = `CCRB_REMIND_S * `CCRB_MCLK_HZ,
    parameter logic [2:0]  VERSION    = 3'b101  // Arbitrary value.
) (
    input  wire logic      mclk,
    input  wire logic      rst,
    input  wire logic      scl,
    input  wire logic      sda_i,
    output logic           sda_o,
    output logic           sda_oe,
    input  wire ccrb_obs_t obs,
    output ccrb_ctl_t      ctl,
    output logic           int_o,
    output logic           int_oe
);
    localparam int unsigned RELEASE_CYC = `CCRB_RELEASE_CYC;

    if (REMIND_CYC <= RELEASE_CYC + 1) begin : g_bad_remind
        $error("REMIND_CYC must exceed the release time");
    end

    // Link side: start detection, clocked by the data line itself.
    logic        start_tog_r;
    always_ff @(negedge sda_i or posedge rst) begin
        if (rst) start_tog_r <= 1'b0;
        else if (scl) start_tog_r <= ~start_tog_r;
    end

    ccrb_phase_t phase_r;
    logic [3:0]  bit_cnt_r;
    logic [6:0]  shift_in_r;
    logic [7:0]  ptr_r, wr_addr_r, wr_data_r, cm_addr_r, cm_data_r, sh_out_r, hold_r;
    logic        ack_me_r, wr_tog_r, pf_tog_r, pf_ack_s1_r, pf_ack_s2_r, pf_ack_r;
    logic        start_seen_r, start_hit_r, sda_oe_r, cm_tog_r;

    wire [7:0] byte_in  = {shift_in_r, sda_i};
    wire       byte_end = (bit_cnt_r == 4'd7);
    wire       addr_hit = (byte_in[7:1] == `CCRB_DEV_ADDR);
    wire       host_nak = (bit_cnt_r == 4'd8) && (phase_r == ph_rdata) && !ack_me_r && sda_i;
    wire       rd_step  = (bit_cnt_r == 4'd0) && (phase_r == ph_rdata);

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            phase_r     <= ph_idle;
            bit_cnt_r   <= 4'd0;
            shift_in_r  <= 7'h00;
            ptr_r       <= 8'h00;
            ack_me_r    <= 1'b0;
            wr_tog_r    <= 1'b0;
            wr_addr_r   <= 8'h00;
            wr_data_r   <= 8'h00;
            pf_tog_r    <= 1'b0;
            pf_ack_s1_r <= 1'b0;
            pf_ack_s2_r <= 1'b0;
        end else begin
            pf_ack_s1_r <= pf_ack_r;
            pf_ack_s2_r <= pf_ack_s1_r;
            if (start_hit_r) begin
                phase_r    <= ph_addr;
                bit_cnt_r  <= 4'd1;
                shift_in_r <= {6'h00, sda_i};
                ack_me_r   <= 1'b0;
            end else if (phase_r != ph_idle) begin
                shift_in_r <= byte_in[6:0];
                bit_cnt_r  <= (bit_cnt_r == 4'd8) ? 4'd0 : bit_cnt_r + 4'd1;
                if (host_nak) phase_r <= ph_idle;
                // Next byte is prefetched while the current one shifts out.
                if (rd_step) begin
                    ptr_r    <= ptr_r + 8'h01;
                    pf_tog_r <= ~pf_tog_r;
                end
                if (byte_end) begin
                    ack_me_r <= (phase_r != ph_rdata) && (phase_r != ph_addr || addr_hit);
                    unique case (phase_r)
                        ph_addr: begin
                            if (!addr_hit) phase_r <= ph_idle;
                            else if (byte_in[0]) phase_r <= ph_rdata;
                            else phase_r <= ph_ptr;
                        end
                        ph_ptr: begin
                            ptr_r    <= byte_in;
                            pf_tog_r <= ~pf_tog_r;
                            phase_r  <= ph_wdata;
                        end
                        ph_wdata: begin
                            wr_addr_r <= ptr_r;
                            wr_data_r <= byte_in;
                            wr_tog_r  <= ~wr_tog_r;
                            ptr_r     <= ptr_r + 8'h01;
                            pf_tog_r  <= ~pf_tog_r;
                        end
                        ph_rdata: ;
                        default: phase_r <= ph_idle;
                    endcase
                end
            end
        end
    end

    // The data line is held for far longer than one half scl period after a
    // start, so start_tog_r is stable when sampled here.
    wire       hold_ok = (pf_ack_s2_r == pf_tog_r);
    wire [7:0] tx_byte = hold_ok ? hold_r : 8'hFF;

    always_ff @(negedge scl or posedge rst) begin
        if (rst) begin
            start_seen_r <= 1'b0;
            start_hit_r  <= 1'b0;
            sda_oe_r     <= 1'b0;
            sh_out_r     <= 8'h00;
            cm_tog_r     <= 1'b0;
            cm_addr_r    <= 8'h00;
            cm_data_r    <= 8'h00;
        end else begin
            start_seen_r <= start_tog_r;
            start_hit_r  <= (start_tog_r != start_seen_r);
            if (start_tog_r != start_seen_r) begin
                sda_oe_r <= 1'b0;
            end else if (bit_cnt_r == 4'd8 && ack_me_r) begin
                sda_oe_r <= 1'b1;
            end else if (rd_step) begin
                sh_out_r <= tx_byte;
                sda_oe_r <= ~tx_byte[7];
                if (hold_ok) begin
                    cm_addr_r <= ptr_r;
                    cm_data_r <= tx_byte;
                    cm_tog_r  <= ~cm_tog_r;
                end
            end else if (phase_r == ph_rdata && bit_cnt_r < 4'd8) begin
                sh_out_r <= {sh_out_r[6:0], 1'b0};
                sda_oe_r <= ~sh_out_r[6];
            end else begin
                sda_oe_r <= 1'b0;
            end
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_r;

    // Core side: event crossings and input filtering.
    logic [2:0] wr_s_r, pf_s_r, cm_s_r;
    ccrb_obs_t  obs_q1_r, obs_q2_r, obs_q3_r, obs_r;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_s_r   <= 3'b000;
            pf_s_r   <= 3'b000;
            cm_s_r   <= 3'b000;
            obs_q1_r <= '0;
            obs_q2_r <= '0;
            obs_q3_r <= '0;
        end else begin
            wr_s_r   <= {wr_s_r[1:0], wr_tog_r};
            pf_s_r   <= {pf_s_r[1:0], pf_tog_r};
            cm_s_r   <= {cm_s_r[1:0], cm_tog_r};
            obs_q1_r <= obs;
            obs_q2_r <= obs_q1_r;
            obs_q3_r <= obs_q2_r;
        end
    end
    wire wr_ev = wr_s_r[2] ^ wr_s_r[1];
    wire pf_ev = pf_s_r[2] ^ pf_s_r[1];
    wire cm_ev = cm_s_r[2] ^ cm_s_r[1];

    // A bit moves only once the second and third stages agree.
    wire [18:0] obs_agree = ~(obs_q2_r ^ obs_q3_r);
    wire ccrb_obs_t obs_nxt = (obs_q2_r & obs_agree) | (obs_r & ~obs_agree);

    logic [7:0] ctl_r [0:13];
    logic [7:0] msk_r [0:3];
    logic [7:0] flag_a_r, flag_b_r;

    function automatic logic [7:0] ctl_rst(input int i);
        case (i)
            1:       return `CCRB_RST_SYS2;
            3:       return `CCRB_RST_CV;
            4:       return `CCRB_RST_TH;
            5:       return `CCRB_RST_FLOOR;
            6:       return `CCRB_RST_CC;
            7:       return `CCRB_RST_EOC_A;
            10:      return `CCRB_RST_HOSTTO;
            12:      return `CCRB_RST_TEMP;
            13:      return `CCRB_RST_TLEVEL;
            default: return 8'h00;
        endcase
    endfunction : ctl_rst

    function automatic logic [7:0] msk_rst(input int i);
        case (i)
            0:       return `CCRB_RST_MSK_STAT;
            1:       return `CCRB_RST_MSK_FAULT;
            2:       return `CCRB_RST_MSK_A;
            default: return `CCRB_RST_MSK_B;
        endcase
    endfunction : msk_rst

    wire       soft_rst = ctl_r[0][`CCRB_BIT_REG_RESET];
    wire [3:0] warn_lvl = ctl_r[13][7:4];
    wire [3:0] rel_lvl  = ctl_r[13][3:0];

    wire       temp_h_set = (obs_nxt.temp_code > warn_lvl) && !(obs_r.temp_code > warn_lvl);
    wire       temp_l_set = (obs_nxt.temp_code < rel_lvl) && !(obs_r.temp_code < rel_lvl);
    wire       stat_chg   = |((obs_nxt.live ^ obs_r.live) & ~msk_r[0][7:5]);
    wire       fault_chg  = |((obs_nxt.fault ^ obs_r.fault) & ~msk_r[1][7:5]);
    wire [7:0] set_a = {obs_nxt.evt_a & ~obs_r.evt_a, temp_h_set, temp_l_set, 1'b0, stat_chg, fault_chg};
    wire [7:0] set_b = {obs_nxt.evt_b & ~obs_r.evt_b, 4'h0};
    wire [7:0] clr_a = (cm_ev && cm_addr_r == `CCRB_OFF_FLAG_A) ? cm_data_r : 8'h00;
    wire [7:0] clr_b = (cm_ev && cm_addr_r == `CCRB_OFF_FLAG_B) ? cm_data_r : 8'h00;
    wire       wr_ctl = wr_ev && wr_addr_r <= `CCRB_OFF_TLEVEL && wr_addr_r != `CCRB_OFF_HOLE;
    wire       wr_msk = wr_ev && wr_addr_r[7:2] == 6'(`CCRB_OFF_MSK_STAT >> 2);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 14; i++) ctl_r[i] <= ctl_rst(i);
            for (int i = 0; i < 4; i++) msk_r[i] <= msk_rst(i);
            flag_a_r <= 8'h00;
            flag_b_r <= 8'h00;
            obs_r    <= '0;
        end else if (soft_rst) begin
            for (int i = 0; i < 14; i++) ctl_r[i] <= ctl_rst(i);
            for (int i = 0; i < 4; i++) msk_r[i] <= msk_rst(i);
            flag_a_r <= 8'h00;
            flag_b_r <= 8'h00;
            obs_r    <= obs_nxt;
        end else begin
            if (wr_ctl) ctl_r[wr_addr_r[3:0]] <= wr_data_r;
            if (wr_msk) msk_r[wr_addr_r[1:0]] <= wr_data_r;
            // A flag raised in the cycle it is read away stays set.
            flag_a_r <= (flag_a_r & ~clr_a) | set_a;
            flag_b_r <= (flag_b_r & ~clr_b) | set_b;
            obs_r    <= obs_nxt;
        end
    end

    function automatic logic [7:0] rd_val(input logic [7:0] a);
        case (a)
            `CCRB_OFF_HOLE:      return 8'h00;
            `CCRB_OFF_TEMP:      return {obs_r.temp_code, ctl_r[12][3:0]};
            `CCRB_OFF_STATE:     return {obs_r.chg_state, 2'b00, VERSION, 1'b0};
            `CCRB_OFF_LIVE:      return {obs_r.live, 5'h00};
            `CCRB_OFF_FAULT:     return {obs_r.fault, 5'h00};
            `CCRB_OFF_FLAG_A:    return flag_a_r;
            `CCRB_OFF_FLAG_B:    return flag_b_r;
            `CCRB_OFF_MSK_STAT:  return msk_r[0];
            `CCRB_OFF_MSK_FAULT: return msk_r[1];
            `CCRB_OFF_MSK_A:     return msk_r[2];
            `CCRB_OFF_MSK_B:     return msk_r[3];
            default:             return (a <= `CCRB_OFF_TLEVEL) ? ctl_r[a[3:0]] : 8'h00;
        endcase
    endfunction : rd_val

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold_r   <= 8'h00;
            pf_ack_r <= 1'b0;
        end else if (pf_ev) begin
            hold_r   <= rd_val(ptr_r);
            pf_ack_r <= pf_s_r[1];
        end
    end

    function automatic logic [4:0] cc_clamp(input logic [4:0] c);
        if (c < `CCRB_CC_MIN) return `CCRB_CC_MIN;
        if (c > `CCRB_CC_MAX) return `CCRB_CC_MAX;
        return c;
    endfunction : cc_clamp

    assign ctl.charge_enable_bit          = ctl_r[1][`CCRB_BIT_CHARGE_ENABLE_BIT];
    assign ctl.switching_frequency_select = ctl_r[2][`CCRB_BIT_FREQ_SEL];
    assign ctl.fixed_frequency_bit        = ctl_r[2][`CCRB_BIT_FIX_FREQ];
    assign ctl.spread_spectrum_enable     = ctl_r[2][`CCRB_BIT_SPREAD];
    assign ctl.battery_voltage_field      = ctl_r[3][7:2];
    assign ctl.thermal_threshold_field    = ctl_r[4][7:6];
    assign ctl.input_voltage_floor_field  = (ctl_r[5][7:1] > `CCRB_FLOOR_MAX) ? `CCRB_FLOOR_MAX : ctl_r[5][7:1];
    assign ctl.input_floor_loop_enable    = ctl_r[5][`CCRB_BIT_FLOOR_EN];
    assign ctl.charge_current_field       = cc_clamp(ctl_r[6][7:3]);
    assign ctl.temp_enable                = ctl_r[12][3];
    assign ctl.temp_avg                   = ctl_r[12][2];

    // Interrupt pin with optional reminder: released for a short gap at the
    // end of every reminder period while something stays pending.
    wire        pend     = |(flag_a_r & ~msk_r[2]) || |(flag_b_r & ~msk_r[3]);
    wire        remind   = ctl_r[1][`CCRB_BIT_REMIND];
    logic [31:0] rem_cnt_r;
    logic        int_oe_r;
    wire        rem_gap  = remind && rem_cnt_r >= 32'(REMIND_CYC - RELEASE_CYC);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rem_cnt_r <= 32'h0;
            int_oe_r  <= 1'b0;
        end else begin
            if (pend && remind) rem_cnt_r <= (rem_cnt_r == 32'(REMIND_CYC - 1)) ? 32'h0 : rem_cnt_r + 32'h1;
            else rem_cnt_r <= 32'h0;
            int_oe_r <= pend && !rem_gap;
        end
    end
    assign int_o  = 1'b0;
    assign int_oe = int_oe_r;

    a_temp_code_read: assert property (@(posedge mclk) disable iff (rst)
        pf_ev && ptr_r == `CCRB_OFF_TEMP |=> hold_r[7:4] == $past(obs_r.temp_code))
        else $error("temperature code not reported");
    a_temp_high_flag: assert property (@(posedge mclk) disable iff (rst)
        temp_h_set && !soft_rst |=> flag_a_r[`CCRB_BIT_TEMP_H])
        else $error("high temperature flag missed");
    a_temp_low_flag: assert property (@(posedge mclk) disable iff (rst)
        temp_l_set && !soft_rst |=> flag_a_r[`CCRB_BIT_TEMP_L])
        else $error("low temperature flag missed");
    a_level_defaults: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> warn_lvl == 4'h3 && rel_lvl == 4'h0)
        else $error("temperature levels not restored");
    a_floor_saturate: assert property (@(posedge mclk) disable iff (rst)
        ctl_r[5][7:6] == 2'b11 |-> ctl.input_voltage_floor_field == 7'h5F)
        else $error("input floor not saturated");
    a_current_range: assert property (@(posedge mclk) disable iff (rst)
        ctl.charge_current_field >= 5'h06 && ctl.charge_current_field <= 5'h1E)
        else $error("charge current out of range");
    a_reset_self_clear: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> !soft_rst && !ctl.charge_enable_bit && ctl_r[6] == 8'hA0)
        else $error("register reset incomplete");
    a_status_change: assert property (@(posedge mclk) disable iff (rst)
        stat_chg && !soft_rst |=> flag_a_r[`CCRB_BIT_STAT_CHG])
        else $error("status change flag missed");
    a_pin_follows: assert property (@(posedge mclk) disable iff (rst)
        pend && !remind |=> int_oe_r)
        else $error("interrupt pin not driven");
    a_remind_gap: assert property (@(posedge mclk) disable iff (rst)
        remind && pend && !soft_rst && rem_cnt_r == 32'(REMIND_CYC - RELEASE_CYC) |=> !int_oe_r)
        else $error("reminder gap missing");
    a_addr_miss: assert property (@(posedge scl) disable iff (rst)
        phase_r == ph_addr && byte_end && !start_hit_r && !addr_hit |=> phase_r == ph_idle)
        else $error("foreign address accepted");

    // A read that races a new event must clear only what it reported.
    a_flag_set_wins: assert property (@(posedge mclk) disable iff (rst)
        |set_a && !soft_rst |=> (flag_a_r & $past(set_a)) == $past(set_a))
        else $error("event flag lost to read clear");
    a_read_clears: assert property (@(posedge mclk) disable iff (rst)
        cm_ev && cm_addr_r == `CCRB_OFF_FLAG_A |=> (flag_a_r & $past(cm_data_r) & ~$past(set_a)) == 8'h00)
        else $error("read flags not cleared");
    a_clock_defaults: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> !ctl.switching_frequency_select && !ctl.fixed_frequency_bit && !ctl.spread_spectrum_enable)
        else $error("clock options not restored");
    a_mask_blocks_pin: assert property (@(posedge mclk) disable iff (rst)
        (flag_a_r & ~msk_r[2]) == 8'h00 && (flag_b_r & ~msk_r[3]) == 8'h00 |=> !int_oe_r)
        else $error("masked event drives interrupt");
endmodule : ccrb_top

// *** ccrb_host.sv ***
`timescale 1ns/1ps
module ccrb_host (
    output logic      scl,
    output logic      pull,
    input  wire logic sda
);
    // The host only ever pulls the data line low; a released line rises on its pull-up.
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task automatic xfer(input logic b, output logic r);
        scl = 1'b0;
        #3.75 pull = ~b;
        #3.75 scl = 1'b1;
        r = sda;
        #7.5;
    endtask : xfer
    // Clock stays parked high between frames; data moves while it is high only here.
    task automatic frame(input logic stop);
        scl = 1'b0;
        #3.75 pull = stop;
        #3.75 scl = 1'b1;
        #3.75 pull = ~stop;
        #3.75;
    endtask : frame
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) xfer(d[i], r[i]);
        xfer(1'b1, n);
        ack = ~n;
    endtask : byte_io
    task automatic access(input logic [6:0] dev, input logic rnw, input logic [7:0] ptr,
                          input logic [7:0] wd, output logic [7:0] rd, output logic ok);
        logic [7:0] dc;
        logic       a0;
        logic       a1;
        logic       a2;
        frame(1'b0);
        byte_io({dev, 1'b0}, dc, a0);
        byte_io(ptr, dc, a1);
        a2 = 1'b1;
        if (rnw) begin
            frame(1'b0);
            byte_io({dev, 1'b1}, dc, a2);
        end
        // The read byte ends with the line released, which is the closing NACK.
        byte_io(rnw ? 8'hFF : wd, rd, ok);
        frame(1'b1);
        ok = rnw ? (a0 & a1 & a2) : (a0 & a1 & ok);
    endtask : access
endmodule : ccrb_host

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import ccrb_pkg::*;
    localparam logic [6:0] DEV = 7'h4B;
    logic       mclk;
    logic       rst;
    logic       scl;
    logic       pull;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic       int_o;
    logic       int_oe;
    logic       ack;
    logic [7:0] rd;
    ccrb_obs_t  obs;
    ccrb_ctl_t  ctl;
    int         fail_count;
    int         n_tests;
    int         seed;
    int         cnt;
    int         mdl [0:255];
    int         offs [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0D};
    int         rstv [8] = '{8'h00, 8'h40, 8'h00, 8'h50, 8'hC0, 8'h0B, 8'hA0, 8'h30};
    int         bnd [4]  = '{8'hBE, 8'hC1, 8'h28, 8'hF8};
    assign sda = ~(pull | (sda_oe & ~sda_o));
    ccrb_top #(.REMIND_CYC(500), .VERSION(3'b011)) dut_u (
        .mclk   (mclk),
        .rst    (rst),
        .scl    (scl),
        .sda_i  (sda),
        .sda_o  (sda_o),
        .sda_oe (sda_oe),
        .obs    (obs),
        .ctl    (ctl),
        .int_o  (int_o),
        .int_oe (int_oe)
    );
    ccrb_host host_u (
        .scl  (scl),
        .pull (pull),
        .sda  (sda)
    );
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic ev(input logic v);
        tick(20);
        check({int_o, int_oe}, {1'b0, v});
    endtask : ev
    task automatic wait_int(input logic v, input int lim);
        cnt = 0;
        while (int_oe !== v && cnt < lim) begin
            tick(1);
            cnt++;
        end
        if (cnt >= lim) begin
            check(1'b0, 1'b1);
            end_sim();
        end
    endtask : wait_int
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        host_u.access(DEV, 1'b0, ptr, d, rd, ack);
        check(ack, 1'b1);
        mdl[ptr] = d;
        tick(10);
    endtask : wr
    task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
        host_u.access(DEV, 1'b1, ptr, 8'h00, rd, ack);
        check({ack, rd}, {1'b1, exp});
        tick(10);
    endtask : rd_chk
    task automatic init_mdl();
        foreach (offs[i]) mdl[offs[i]] = rstv[i];
        mdl[12] = 8'h08;
    endtask : init_mdl
    function automatic ccrb_ctl_t exp_ctl();
        ccrb_ctl_t  c;
        logic [6:0] fl;
        logic [4:0] cc;
        fl = mdl[5][7:1];
        cc = mdl[6][7:3];
        c.charge_enable_bit = mdl[1][7];
        c.switching_frequency_select = mdl[2][7];
        c.fixed_frequency_bit = mdl[2][6];
        c.spread_spectrum_enable = mdl[2][5];
        c.battery_voltage_field = mdl[3][7:2];
        c.thermal_threshold_field = mdl[4][7:6];
        // Out-of-range codes saturate instead of wrapping.
        c.input_voltage_floor_field = (fl > 7'h5F) ? 7'h5F : fl;
        c.input_floor_loop_enable = mdl[5][0];
        c.charge_current_field = (cc < 5'h06) ? 5'h06 : ((cc > 5'h1E) ? 5'h1E : cc);
        c.temp_enable = mdl[12][3];
        c.temp_avg = mdl[12][2];
        return c;
    endfunction : exp_ctl
    initial begin
        seed = 32'h0B2B9EDF;
        fail_count = 0;
        n_tests = 0;
        obs = '0;
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        init_mdl();
        tick(4);
        check(ctl, exp_ctl());
        foreach (offs[i]) rd_chk(8'(offs[i]), 8'(rstv[i]));
        rd_chk(8'h0C, 8'h08);
        repeat (6) begin
            for (int a = 1; a < 7; a++) wr(8'(a), 8'($random(seed)));
            check(ctl, exp_ctl());
            rd_chk(8'h05, 8'(mdl[5]));
        end
        foreach (bnd[i]) begin
            wr(8'h05, 8'(bnd[i]));
            wr(8'h06, 8'(bnd[i]));
            check(ctl, exp_ctl());
        end
        wr(8'h01, 8'h40);
        host_u.access(7'h4A, 1'b0, 8'h01, 8'h80, rd, ack);
        tick(10);
        check({ack, ctl}, {1'b0, exp_ctl()});
        obs.temp_code = 4'h3;
        tick(20);
        wr(8'h0D, 8'h52);
        wr(8'h42, 8'hE4);
        rd_chk(8'h32, 8'h00);
        obs.temp_code = 4'h5;
        ev(1'b0);
        obs.temp_code = 4'h6;
        ev(1'b1);
        rd_chk(8'h0C, 8'h68);
        wr(8'h0C, 8'hF4);
        rd_chk(8'h0C, 8'h64);
        rd_chk(8'h32, 8'h10);
        ev(1'b0);
        obs.temp_code = 4'h2;
        ev(1'b0);
        obs.temp_code = 4'h1;
        ev(1'b1);
        rd_chk(8'h32, 8'h08);
        obs.live = 3'b100;
        obs.chg_state = 2'b10;
        ev(1'b1);
        rd_chk(8'h30, 8'h80);
        rd_chk(8'h20, 8'h86);
        rd_chk(8'h32, 8'h02);
        obs.fault = 3'b001;
        ev(1'b0);
        rd_chk(8'h32, 8'h00);
        wr(8'h41, 8'h00);
        obs.fault = 3'b011;
        ev(1'b1);
        rd_chk(8'h32, 8'h01);
        obs.evt_a = 3'b111;
        ev(1'b0);
        rd_chk(8'h32, 8'hE0);
        obs.evt_b = 4'h9;
        ev(1'b0);
        rd_chk(8'h33, 8'h90);
        wr(8'h01, 8'h48);
        obs.live = 3'b000;
        wait_int(1'b1, 30);
        wait_int(1'b0, 600);
        wait_int(1'b1, 300);
        check(cnt, 100);
        rd_chk(8'h32, 8'h02);
        wr(8'h00, 8'h80);
        init_mdl();
        check({int_oe, ctl}, {1'b0, exp_ctl()});
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h42, 8'hFF);
        rd_chk(8'h0D, 8'h30);
        end_sim();
    end
    initial begin
        #900000;
        check(1'b0, 1'b1);
        end_sim();
    end
endmodule : tb_top
